// ==== fnc_chk.sv ====
// checker: result timing and first-byte verdicts of fnc_top
`timescale 1ns/100ps
module fnc_chk
#(
	parameter int LEN = 8
)
(
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	input wire logic       BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	input wire logic       COMMIT,
	input wire logic       DIR_CLEAR,
	input wire logic       DONE,
	input wire logic       PASS,
	input wire logic [3:0] FAIL_CODE,
	input wire logic       DIR_FULL
);
	int         cnt_ff;
	logic [7:0] first_ff;
	// byte 0 verdict decides the code, since the first failing byte wins
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			cnt_ff <= 0;
		else if (BYTE_VALID)
			cnt_ff <= (cnt_ff == LEN - 1) ? 0 : cnt_ff + 1;
		if (BYTE_VALID && cnt_ff == 0)
			first_ff <= BYTE_DATA;
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_last; BYTE_VALID && cnt_ff == LEN - 1; endsequence
	sequence s_res; DONE; endsequence
	property p_done; s_last |=> s_res ##1 !DONE; endproperty
	a_done: assert property (p_done) else $error("bad result pulse");
	property p_quiet; !(BYTE_VALID && cnt_ff == LEN - 1) |=> !DONE;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray result");
	property p_pass; DONE |-> PASS == (FAIL_CODE == 4'h0); endproperty
	a_pass: assert property (p_pass) else $error("pass vs code");
	property p_hi; DONE && first_ff >= 8'h7F |-> FAIL_CODE == 4'h1; endproperty
	a_hi: assert property (p_hi) else $error("high byte");
	property p_ctl; DONE && first_ff < 8'h20 && first_ff != 8'h00
		|-> FAIL_CODE == 4'h2; endproperty
	a_ctl: assert property (p_ctl) else $error("control byte");
	property p_sp; DONE && first_ff == 8'h20 |-> FAIL_CODE == 4'h4; endproperty
	a_sp: assert property (p_sp) else $error("leading space");
	property p_dot; DONE && first_ff == 8'h2E |-> FAIL_CODE == 4'h6; endproperty
	a_dot: assert property (p_dot) else $error("leading period");
	property p_emp; DONE && first_ff == 8'h00 |-> FAIL_CODE == 4'h7; endproperty
	a_emp: assert property (p_emp) else $error("empty name");
	property p_clr; DIR_CLEAR |=> !DIR_FULL; endproperty
	a_clr: assert property (p_clr) else $error("full after clear");
endmodule : fnc_chk
bind fnc_top fnc_chk #(.LEN(LEN)) u_fnc_chk (.CORE_CLK(CORE_CLK),
	.RST_N(RST_N), .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
	.COMMIT(COMMIT), .DIR_CLEAR(DIR_CLEAR), .DONE(DONE), .PASS(PASS),
	.FAIL_CODE(FAIL_CODE), .DIR_FULL(DIR_FULL));

// ==== fnc_host.sv ====
// partner model: host handing whole name fields to the checker
`timescale 1ns/100ps
module fnc_host
#(
	parameter int LEN = 8
)
(
	input  wire logic  CORE_CLK,
	output logic       BYTE_VALID = 1'b0,
	output logic [7:0] BYTE_DATA  = 8'h00,
	output logic       COMMIT     = 1'b0
);
	// byte 0 first, whole field, commit with the last byte
	task send(input logic [8*LEN-1:0] nm, input logic cm);
		for (int i = 0; i < LEN; i++)
		begin
			@(posedge CORE_CLK);
			BYTE_VALID <= 1'b1;
			BYTE_DATA  <= nm[8*(LEN-1-i) +: 8];
			COMMIT     <= cm && (i == LEN - 1);
		end
		@(posedge CORE_CLK);
		BYTE_VALID <= 1'b0;
		BYTE_DATA  <= ~BYTE_DATA;
		COMMIT     <= 1'b0;
	endtask : send
endmodule : fnc_host

// ==== fnc_top_tb_top.sv ====
// testbench: name fields through the host model into fnc_top
`timescale 1ns/100ps
module fnc_top_tb_top;
	logic        clk, rst_n, clr, vld, cmt, done, pass, full;
	logic [7:0]  dat;
	logic [3:0]  code, e;
	logic [3:0]  exp_q[$];
	logic [63:0] nm;
	logic [7:0]  pl[14] = '{8'h22, 8'h27, 8'h2A, 8'h2F, 8'h3A, 8'h3B, 8'h3C,
		8'h3D, 8'h3E, 8'h3F, 8'h5B, 8'h5C, 8'h5D, 8'h7C};
	int          err_count = 0, tests_run = 0, cyc = 0, seed = 83268;
	fnc_top #(.LEN(8), .DEPTH(2)) u_fnc_top (.CORE_CLK(clk), .RST_N(rst_n),
		.BYTE_VALID(vld), .BYTE_DATA(dat), .COMMIT(cmt), .DIR_CLEAR(clr),
		.DONE(done), .PASS(pass), .FAIL_CODE(code), .DIR_FULL(full));
	fnc_host #(.LEN(8)) u_fnc_host (.CORE_CLK(clk), .BYTE_VALID(vld),
		.BYTE_DATA(dat), .COMMIT(cmt));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task check(input logic [4:0] got, input logic [4:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task finish_test;
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task run(input logic [63:0] n, input logic c, input logic [3:0] x);
		exp_q.push_back(x);
		u_fnc_host.send(n, c);
	endtask : run
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			finish_test();
		end
		else if (done === 1'b1)
		begin
			e = exp_q.pop_front();
			check({pass, code}, {e == 4'h0, e});
		end
	end
	initial
	begin
		rst_n = 1'b0;
		clr = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		run({"ab", 48'h0}, 1'b1, 4'h0);
		run({"ab", 48'h0}, 1'b1, 4'h9);
		run({"aB", 48'h0}, 1'b1, 4'h0);
		run({"cd", 48'h0}, 1'b1, 4'hA);
		@(negedge clk) check({4'h0, full}, 5'h01);
		run({8'h7F, 56'h0}, 1'b0, 4'h1);
		run({8'h1F, 56'h0}, 1'b0, 4'h2);
		foreach (pl[i]) run({"a", pl[i], 48'h0}, 1'b0, 4'h3);
		run({" a", 48'h0}, 1'b0, 4'h4);
		run({"a ", 48'h0}, 1'b0, 4'h5);
		run({".a", 48'h0}, 1'b0, 4'h6);
		run(64'h0, 1'b0, 4'h7);
		run({"a", 8'h00, "b", 40'h0}, 1'b0, 4'h8);
		nm = {$random(seed), $random(seed)} & 64'h0F0F0F0F0F0F0F0F;
		nm = nm | 64'h6060606060606060;
		run(nm, 1'b0, 4'h0);
		run({nm[63:8], " "}, 1'b0, 4'h5);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		run({"ab", 48'h0}, 1'b1, 4'h0);
		repeat (3) @(posedge clk);
		check({4'h0, exp_q.size() == 0}, 5'h01);
		finish_test();
	end
endmodule : fnc_top_tb_top

// ==== fncbyte.sv ====
// module: classifies one name byte against the character set
`timescale 1ns/100ps
module fnc_byte
(
	fnc_byte_if.cls bi
);
	always_comb
	begin
		bi.bad  = 1'b1;
		bi.code = fnc_pkg::FNC_OK;
		if (bi.data > fnc_pkg::CHAR_MAX)                       // [R1]
			bi.code = fnc_pkg::FNC_HIGH;
		else if (bi.data < fnc_pkg::CHAR_MIN)                  // [R2]
			bi.code = fnc_pkg::FNC_CTRL;
		else if (fnc_pkg::fnc_is_punct(bi.data))               // [R3]
			bi.code = fnc_pkg::FNC_PUNCT;
		else
			bi.bad = 1'b0;
	end
endmodule : fnc_byte

// ==== fncif.sv ====
// interface: per-byte verdict from the byte classifier
`timescale 1ns/100ps
interface fnc_byte_if;
	logic [7:0]       data;
	logic             bad;
	fnc_pkg::fnc_code_t code;
	modport cls (input data, output bad, output code);
	modport top (output data, input bad, input code);
endinterface : fnc_byte_if

// ==== fncpkg.sv ====
// package: constants and types for the file-name field checker
package fnc_pkg;

	localparam int          FIELD_LEN    = 32;
	localparam logic [7:0]  CHAR_NUL     = 8'h00;
	localparam logic [7:0]  CHAR_MIN     = 8'h20;
	localparam logic [7:0]  CHAR_MAX     = 8'h7E;
	localparam logic [7:0]  CHAR_SPACE   = 8'h20;
	localparam logic [7:0]  CHAR_PERIOD  = 8'h2E;
	localparam int          DICT_DEPTH   = 16;
	localparam logic [3:0]  RST_CODE     = 4'h0;

	typedef enum logic [3:0]
	{
		FNC_OK        = 4'h0,
		FNC_HIGH      = 4'h1,
		FNC_CTRL      = 4'h2,
		FNC_PUNCT     = 4'h3,
		FNC_LEAD_SP   = 4'h4,
		FNC_TRAIL_SP  = 4'h5,
		FNC_LEAD_DOT  = 4'h6,
		FNC_EMPTY     = 4'h7,
		FNC_PAD       = 4'h8,
		FNC_DUP       = 4'h9,
		FNC_FULL      = 4'hA
	} fnc_code_t;

	// forbidden punctuation set
	function automatic logic fnc_is_punct(input logic [7:0] c);
		case (c)
			8'h22, 8'h27, 8'h2A, 8'h2F, 8'h3A, 8'h3B, 8'h3C,
			8'h3D, 8'h3E, 8'h3F, 8'h5B, 8'h5C, 8'h5D, 8'h7C:
				fnc_is_punct = 1'b1;
			default:
				fnc_is_punct = 1'b0;
		endcase
	endfunction : fnc_is_punct

endpackage : fnc_pkg

// ==== fnctop.sv ====
// module: file-name field checker with duplicate-name dictionary
// How it works
// (R1) bytes at 0x7F or above are flagged as violations.
// (R2) codes below 0x20 are forbidden except zero as terminator.
// (R3) the fourteen listed punctuation codes are rejected.
// (R4) names compare byte-exact, letter case is never folded.
// (R5) a name may neither start nor end with a space.
// (R6) a name may not start with a period.
// (R7) name starts at byte 0, contiguous, ended by one zero byte.
// (R8) every byte after the terminator must be zero.
// (R9) a name filling the whole field needs no terminator.
// (R10) byte 0 arrives first, bit 7 of each byte is its MSB.
// (R11) duplicate names are refused using exact comparison.
// (R12) one-cycle pass/fail with first-failing code after last byte.
`timescale 1ns/100ps
module fnc_top
#(
	parameter int LEN   = fnc_pkg::FIELD_LEN,
	parameter int DEPTH = fnc_pkg::DICT_DEPTH
)
(
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	input  wire logic       BYTE_VALID,
	input  wire logic [7:0] BYTE_DATA,
	input  wire logic       COMMIT,
	input  wire logic       DIR_CLEAR,
	output logic            DONE,
	output logic            PASS,
	output logic [3:0]      FAIL_CODE,
	output logic            DIR_FULL
);
	// -----------------------------------------------------------
	// sizes
	// -----------------------------------------------------------
	localparam int PW = $clog2(LEN + 1);
	// the entry count must reach DEPTH itself to show a full directory
	localparam int DW = $clog2(DEPTH + 1);

	// -----------------------------------------------------------
	// state record
	// -----------------------------------------------------------
	// the directory rides in the record: DEPTH words of LEN bytes
	typedef struct packed
	{
		logic [PW-1:0]            pos;
		logic                     ended;
		logic [7:0]               last;
		logic [3:0]               code;
		logic [LEN*8-1:0]         name;
		logic [DEPTH-1:0][LEN*8-1:0] dict;
		logic [DW-1:0]            count;
		logic                     done;
		logic                     pass;
		logic [3:0]               out_code;
		logic                     full;
	} fnc_state_t;

	fnc_state_t st_ff;
	fnc_state_t nxt_st;
	fnc_byte_if bi ();

	// -----------------------------------------------------------
	// byte classifier
	// -----------------------------------------------------------
	// character-set tests sit apart so a name builder can reuse them
	assign bi.data = BYTE_DATA;

	fnc_byte u_byte
	(
		.bi (bi)
	);

	// -----------------------------------------------------------
	// position rules
	// -----------------------------------------------------------
	// verdict for the zero byte that ends a name
	function automatic logic [3:0] term_code
	(
		input logic       at_first,
		input logic [7:0] prev
	);
		term_code = fnc_pkg::FNC_OK;
		if (at_first)
			term_code = fnc_pkg::FNC_EMPTY;         // [R7]
		else if (prev == fnc_pkg::CHAR_SPACE)
			term_code = fnc_pkg::FNC_TRAIL_SP;      // [R5]
	endfunction : term_code

	// verdict for a byte that already passed the character-set tests
	function automatic logic [3:0] place_code
	(
		input logic [7:0] c,
		input logic       at_first,
		input logic       at_last
	);
		place_code = fnc_pkg::FNC_OK;
		if (at_first && c == fnc_pkg::CHAR_SPACE)
			place_code = fnc_pkg::FNC_LEAD_SP;      // [R5]
		else if (at_first && c == fnc_pkg::CHAR_PERIOD)
			place_code = fnc_pkg::FNC_LEAD_DOT;     // [R6]
		else if (at_last && c == fnc_pkg::CHAR_SPACE)
			place_code = fnc_pkg::FNC_TRAIL_SP;     // [R5] [R9]
	endfunction : place_code

	// -----------------------------------------------------------
	// name assembly and dictionary compare
	// -----------------------------------------------------------
	logic             first_byte;
	logic             last_byte;
	logic [3:0]       bcode;
	logic             dup;
	logic [LEN*8-1:0] fin_name;
	logic [DEPTH-1:0] hit;

	assign first_byte = (st_ff.pos == '0);
	assign last_byte  = (st_ff.pos == PW'(LEN - 1));

	// byte 0 lands in the top lane so the field reads msb first [R10]
	always_comb
	begin
		fin_name = st_ff.name;
		fin_name[(LEN-1-int'(st_ff.pos))*8 +: 8] = BYTE_DATA;
	end

	// one comparator per slot: wide, but the verdict is ready with the
	// last byte, so no extra result cycle is paid for it
	generate
		for (genvar g = 0; g < DEPTH; g++)
		begin : g_slot
			// whole-field exact compare, no case folding [R4] [R11]
			assign hit[g] = (DW'(g) < st_ff.count)
				&& (st_ff.dict[g] == fin_name);
		end
	endgenerate

	assign dup = |hit;

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		bcode       = fnc_pkg::FNC_OK;
		// idle cycles leave the field position where it was
		if (BYTE_VALID)
		begin
			if (st_ff.ended)
			begin
				if (BYTE_DATA != fnc_pkg::CHAR_NUL)                   // [R8]
					bcode = fnc_pkg::FNC_PAD;
			end
			else if (BYTE_DATA == fnc_pkg::CHAR_NUL)
			begin
				bcode = term_code(first_byte, st_ff.last); // [R5] [R7]
				nxt_st.ended = 1'b1;                                  // [R7]
			end
			else if (bi.bad)                                       // [R1] [R2] [R3]
				bcode = bi.code;
			else
				bcode = place_code(BYTE_DATA, first_byte, last_byte);
			// only the first failure is kept
			if (st_ff.code == fnc_pkg::FNC_OK)
				nxt_st.code = bcode;
			nxt_st.last = BYTE_DATA;
			nxt_st.name = fin_name;
			nxt_st.pos  = st_ff.pos + PW'(1);
			if (last_byte)
			begin
				nxt_st.done     = 1'b1;                               // [R12]
				nxt_st.out_code = nxt_st.code;
				if (nxt_st.code == fnc_pkg::FNC_OK && dup)
					nxt_st.out_code = fnc_pkg::FNC_DUP;               // [R11]
				else if (nxt_st.code == fnc_pkg::FNC_OK && COMMIT
					&& st_ff.count == DW'(DEPTH))
					nxt_st.out_code = fnc_pkg::FNC_FULL;
				nxt_st.pass = (nxt_st.out_code == fnc_pkg::FNC_OK);   // [R12]
				// a passing name is entered only when the writer commits it
				if (nxt_st.pass && COMMIT)
				begin
					nxt_st.dict[st_ff.count] = fin_name;
					nxt_st.count = st_ff.count + DW'(1);
				end
				nxt_st.pos   = '0;
				nxt_st.ended = 1'b0;
				nxt_st.code  = fnc_pkg::FNC_OK;
				nxt_st.last  = fnc_pkg::CHAR_NUL;
			end
		end
		// clear wins over a commit in the same cycle
		if (DIR_CLEAR)
			nxt_st.count = '0;
		nxt_st.full = (nxt_st.count == DW'(DEPTH));
	end

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	// reset is synchronous; the directory array clears with the rest
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			st_ff          <= '0;
			st_ff.out_code <= fnc_pkg::RST_CODE;
		end
		else
			st_ff <= nxt_st;
	end

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	// every output is a register bit of the state record
	assign DONE      = st_ff.done;
	assign PASS      = st_ff.pass;
	assign FAIL_CODE = st_ff.out_code;
	assign DIR_FULL  = st_ff.full;

endmodule : fnc_top
